/* rtl/rtc_core.v */
// bcd calendar clock with alarms, wakeup timer, tamper and timestamp
// Summary of operation
// RULE1 - the calendar and storage run in every mode, only i_nrst stops them.
// RULE2 - five 32-bit storage words hold twenty bytes of user data.
// RULE3 - storage words are never cleared by any reset.
// RULE4 - time and date are kept as bcd digits, the sub-second as binary.
// RULE5 - hours count in 24-hour form or, when selected, 12-hour with pm.
// RULE6 - the date wraps at 28, 29 in leap years, 30 or 31 by month.
// RULE7 - two alarms, each able to assert the wakeup output.
// RULE8 - a wakeup timer with selectable step and period asserts wakeup.
// RULE9 - software shifts the calendar by 1 to 32767 clock pulses.
// RULE10 - a 50 or 60 Hz reference input may pace the seconds instead.
// RULE11 - calibration removes or adds pulses at 1 ppm resolution.
// RULE12 - two filtered tamper inputs raise flags able to assert wakeup.
// RULE13 - a timestamp pin edge or tamper event captures the calendar.
// RULE14 - a timestamp event is able to assert wakeup.
// RULE15 - the clock is one of crystal, resonator, rc or divided hse.
// RULE16 - prescalers give the sub-second count and a 1 Hz tick.
// RULE17 - an alarm flags when the unmasked fields equal its values.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`include "rtc_defs.vh"
module rtc_core #(
	parameter HSE_DIV = 32,
	parameter BKP_N = 5
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_nrst,
	// register port
	input wire [4:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [31:0] o_rdata,
	// calendar clock sources
	input wire i_low_speed_external_crystal,
	input wire i_ext_resonator,
	input wire i_low_speed_internal_rc,
	input wire i_high_speed_external_clock,
	// external event pins
	input wire [1:0] i_tamper,
	input wire i_tstamp,
	input wire i_refclk,
	// wakeup request
	output reg o_wakeup
);
	reg [7:0] s1, s2, s3, lvl, lvl_d;
	wire [7:0] rise;
	reg [`RTC_C_W-1:0] ctrl;
	reg [6:0] pre_a, apre;
	reg [14:0] pre_s, ss;
	reg [15:0] wut_rl, wut;
	reg [31:0] alra, alrb, ts_time, ts_date;
	reg [15:0] cal;
	reg [`RTC_S_W-1:0] st, st_set;
	reg [4:0] hse_cnt;
	reg hse_tick, upd;
	reg [19:0] win;
	reg [5:0] ref_cnt;
	reg [7:0] sec, min, hr, wd, dt, mo, yr;
	reg pm;
	reg [7:0] next_sec, next_min, next_hr, next_wd, next_dt, next_mo;
	reg [7:0] next_yr;
	reg next_pm;
	reg [3:0] tcnt [0:1];
	reg [1:0] tev;
	reg ck_raw;
	reg [31:0] next_rdata;
	wire [31:0] time_w, date_w;
	wire ck, cal_slot, dbl, ck_a, ref_sec, sec_tick, adv, shift_wr;
	wire wut_step, ts_ev;
	wire is_bkp;
	integer k, q; // one loop index per process keeps each to one driver

	// add one to a two-digit bcd value
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// last date of the month; years 00..99 leap when divisible by four
	function [7:0] last_day;
		input [7:0] m;
		input [7:0] y;
		reg lp;
		begin
			lp = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
				(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
			case (m)
			8'h02: last_day = lp ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
			endcase
		end
	endfunction

	// alarm compare, a set mask bit ignores that field
	function al_hit;
		input [31:0] a;
		input [31:0] t;
		input [31:0] d;
		begin
			al_hit = (a[`RTC_F_SECMSK] | (a[`RTC_F_SEC] == t[`RTC_F_SEC])) &
				(a[`RTC_F_MINMSK] | (a[`RTC_F_MIN] == t[`RTC_F_MIN])) &
				(a[`RTC_F_HRMSK] | (a[`RTC_F_HR] == t[`RTC_F_HR] &&
				a[`RTC_F_PM] == t[`RTC_F_PM])) &
				(a[`RTC_F_DTMSK] | (a[`RTC_F_ADT] == d[`RTC_F_DT]));
		end
	endfunction

	// three-stage sampling of every outside pin; level moves once s2==s3
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			s1 <= 8'h00;
			s2 <= 8'h00;
			s3 <= 8'h00;
			lvl <= 8'h00;
			lvl_d <= 8'h00;
		end else begin
			s1 <= {i_refclk, i_tstamp, i_tamper, i_high_speed_external_clock,
				i_low_speed_internal_rc, i_ext_resonator,
				i_low_speed_external_crystal};
			s2 <= s1;
			s3 <= s2;
			lvl <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
			lvl_d <= lvl;
		end
	end
	assign rise = lvl & ~lvl_d;

	// source select; hse must stay below a quarter of the system clock
	always @* begin
		case (ctrl[`RTC_C_CKSEL])
		2'b00: ck_raw = rise[0]; // RULE15
		2'b01: ck_raw = rise[1];
		2'b10: ck_raw = rise[2];
		default: ck_raw = hse_tick;
		endcase
	end

	// calibration slots: calm masked pulses, calp doubles 512 per window
	assign cal_slot = ck_raw & (win[`RTC_CAL_SLOT] == 11'h000);
	assign ck = ck_raw & ~(cal_slot & (win[`RTC_CAL_IDX] < cal[`RTC_F_CALM]));
	assign dbl = cal_slot & cal[`RTC_F_CALP]; // RULE11
	assign ck_a = ck & (apre == 7'h00);
	assign ref_sec = ctrl[`RTC_C_REFEN] & rise[7] & (ref_cnt ==
		(ctrl[`RTC_C_REF60] ? `RTC_REF60 : `RTC_REF50));
	assign sec_tick = ctrl[`RTC_C_REFEN] ? ref_sec : (ck_a && ss == 15'h0000);
	assign shift_wr = i_wr && i_addr == `RTC_A_SHIFT;
	assign adv = sec_tick | (shift_wr & i_wdata[`RTC_F_ADD1S]);

	// prescaler chain, hse divider, calibration window, reference count
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			hse_cnt <= 5'h00;
			hse_tick <= 1'b0;
			win <= 20'h0_0000;
			apre <= `RTC_PREA_RST;
			ss <= `RTC_PRES_RST;
			ref_cnt <= 6'h00;
		end else begin
			hse_tick <= rise[3] && hse_cnt == HSE_DIV[4:0] - 5'h01;
			if (rise[3])
				hse_cnt <= (hse_cnt == HSE_DIV[4:0] - 5'h01) ? 5'h00 :
					hse_cnt + 5'h01;
			if (ck_raw)
				win <= win + 20'h0_0001; // RULE11
			if (ck) begin
				if (apre == 7'h00)
					apre <= pre_a; // RULE16
				else if (dbl && apre > 7'h01)
					apre <= apre - 7'h02;
				else
					apre <= apre - 7'h01;
			end
			// a shift lengthens the current second by the programmed count
			if (shift_wr)
				ss <= ss + i_wdata[`RTC_F_SUBFS]; // RULE9
			else if (ref_sec || (ck_a && ss == 15'h0000))
				ss <= pre_s; // RULE16
			else if (ck_a && !ctrl[`RTC_C_REFEN])
				ss <= ss - 15'h0001;
			else if (ck_a && ss != 15'h0000)
				ss <= ss - 15'h0001;
			if (!ctrl[`RTC_C_REFEN] || ref_sec)
				ref_cnt <= 6'h00;
			else if (rise[7])
				ref_cnt <= ref_cnt + 6'h01; // RULE10
		end
	end

	// calendar carry chain
	always @* begin
		next_sec = sec;
		next_min = min;
		next_hr = hr;
		next_pm = pm;
		next_wd = wd;
		next_dt = dt;
		next_mo = mo;
		next_yr = yr;
		if (adv) begin
			next_sec = bcd_inc(sec); // RULE4
			if (sec == `RTC_MAX_SEC) begin
				next_sec = 8'h00;
				next_min = bcd_inc(min);
				if (min == `RTC_MAX_SEC) begin
					next_min = 8'h00;
					next_hr = bcd_inc(hr);
					if (ctrl[`RTC_C_FMT12] && hr == `RTC_HR12)
						next_hr = `RTC_ONE; // RULE5
					else if (ctrl[`RTC_C_FMT12] && hr == `RTC_HR11)
						next_pm = ~pm;
					else if (!ctrl[`RTC_C_FMT12] && hr == `RTC_MAX_HR24)
						next_hr = 8'h00;
					if ((ctrl[`RTC_C_FMT12] && hr == `RTC_HR11 && pm) ||
						(!ctrl[`RTC_C_FMT12] && hr == `RTC_MAX_HR24)) begin
						next_wd = (wd == `RTC_MAX_WD) ? `RTC_ONE : wd + 8'h01;
						next_dt = bcd_inc(dt);
						if (dt == last_day(mo, yr)) begin
							next_dt = `RTC_ONE; // RULE6
							next_mo = bcd_inc(mo);
							if (mo == `RTC_MAX_MO) begin
								next_mo = `RTC_ONE;
								next_yr = (yr == `RTC_MAX_YR) ? 8'h00 :
									bcd_inc(yr);
							end
						end
					end
				end
			end
		end
	end

	assign time_w = {9'h000, pm, hr[5:0], 1'b0, min[6:0], 1'b0, sec[6:0]};
	assign date_w = {8'h00, yr, wd[2:0], mo[4:0], 2'b00, dt[5:0]};

	// calendar registers keep counting in every power mode
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			{pm, hr, min, sec} <= {1'b0, 8'h00, 8'h00, 8'h00};
			{yr, wd, mo, dt} <= {8'h00, 8'h01, 8'h01, 8'h01};
			upd <= 1'b0;
		end else begin
			upd <= adv; // RULE1
			if (i_wr && i_addr == `RTC_A_TIME) begin
				sec <= {1'b0, i_wdata[`RTC_F_SEC]};
				min <= {1'b0, i_wdata[`RTC_F_MIN]};
				hr <= {2'b00, i_wdata[`RTC_F_HR]};
				pm <= i_wdata[`RTC_F_PM];
			end else begin
				{sec, min, hr, pm} <= {next_sec, next_min, next_hr, next_pm};
			end
			if (i_wr && i_addr == `RTC_A_DATE) begin
				dt <= {2'b00, i_wdata[`RTC_F_DT]};
				mo <= {3'b000, i_wdata[`RTC_F_MO]};
				wd <= {5'h00, i_wdata[`RTC_F_WD]};
				yr <= i_wdata[`RTC_F_YR];
			end else begin
				{dt, mo, wd, yr} <= {next_dt, next_mo, next_wd, next_yr};
			end
		end
	end

	// tamper filter: 0 acts on the edge, n needs 2^n high samples
	always @* begin
		for (k = 0; k < 2; k = k + 1) begin
			if (ctrl[`RTC_C_FILT] == 2'b00)
				tev[k] = ctrl[9 + k] & rise[4 + k];
			else
				tev[k] = ctrl[9 + k] & ck & lvl[4 + k] &
					(tcnt[k] == (4'h1 << ctrl[`RTC_C_FILT]) - 4'h1); // RULE12
		end
	end

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			tcnt[0] <= 4'h0;
			tcnt[1] <= 4'h0;
		end else begin
			for (q = 0; q < 2; q = q + 1) begin
				if (!lvl[4 + q])
					tcnt[q] <= 4'h0;
				else if (ck && tcnt[q] != 4'hF)
					tcnt[q] <= tcnt[q] + 4'h1;
			end
		end
	end

	assign ts_ev = (ctrl[`RTC_C_TSEN] & rise[6]) |
		(ctrl[`RTC_C_TAMPTS] & |tev); // RULE13
	assign wut_step = ctrl[`RTC_C_WUT1HZ] ? sec_tick : ck_a; // RULE8

	// event flags
	always @* begin
		st_set = {`RTC_S_W{1'b0}};
		st_set[`RTC_S_ALA] = upd & ctrl[`RTC_C_ALAEN] &
			al_hit(alra, time_w, date_w); // RULE17
		st_set[`RTC_S_ALB] = upd & ctrl[`RTC_C_ALBEN] &
			al_hit(alrb, time_w, date_w); // RULE7
		st_set[`RTC_S_WUT] = ctrl[`RTC_C_WUTEN] & wut_step & (wut == 16'h0000);
		st_set[`RTC_S_TS] = ts_ev;
		st_set[`RTC_S_TSOV] = ts_ev & st[`RTC_S_TS];
		st_set[`RTC_S_TAMP] = tev; // RULE12
	end

	// software registers; a flag set in the clearing cycle stays set
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl <= {`RTC_C_W{1'b0}};
			pre_a <= `RTC_PREA_RST;
			pre_s <= `RTC_PRES_RST;
			wut_rl <= `RTC_WUT_RST;
			wut <= `RTC_WUT_RST;
			alra <= 32'h0000_0000;
			alrb <= 32'h0000_0000;
			cal <= 16'h0000;
			st <= {`RTC_S_W{1'b0}};
			ts_time <= 32'h0000_0000;
			ts_date <= 32'h0000_0000;
			o_wakeup <= 1'b0;
		end else begin
			if (i_wr && i_addr == `RTC_A_CTRL)
				ctrl <= i_wdata[`RTC_C_W-1:0];
			if (i_wr && i_addr == `RTC_A_PRE) begin
				pre_a <= i_wdata[`RTC_F_PREA];
				pre_s <= i_wdata[`RTC_F_PRES];
			end
			if (i_wr && i_addr == `RTC_A_ALRA)
				alra <= i_wdata;
			if (i_wr && i_addr == `RTC_A_ALRB)
				alrb <= i_wdata;
			if (i_wr && i_addr == `RTC_A_CAL)
				cal <= i_wdata[15:0];
			if (i_wr && i_addr == `RTC_A_WUT) begin
				wut_rl <= i_wdata[15:0];
				wut <= i_wdata[15:0];
			end else if (!ctrl[`RTC_C_WUTEN]) begin
				wut <= wut_rl;
			end else if (wut_step) begin
				wut <= (wut == 16'h0000) ? wut_rl : wut - 16'h0001; // RULE8
			end
			if (i_wr && i_addr == `RTC_A_STAT)
				st <= (st & i_wdata[`RTC_S_W-1:0]) | st_set;
			else
				st <= st | st_set;
			if (ts_ev) begin
				ts_time <= time_w; // RULE13
				ts_date <= date_w;
			end
			o_wakeup <= |(st & ctrl[`RTC_C_WAKE]); // RULE14
		end
	end

	// readback value, zero outside the read cycle and for gaps in the map
	always @* begin
		next_rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
			`RTC_A_TIME: next_rdata = time_w;
			`RTC_A_DATE: next_rdata = date_w;
			`RTC_A_CTRL: next_rdata = {9'h000, ctrl};
			`RTC_A_PRE: next_rdata = {9'h000, pre_a, 1'b0, pre_s};
			`RTC_A_WUT: next_rdata = {wut, wut_rl};
			`RTC_A_ALRA: next_rdata = alra;
			`RTC_A_ALRB: next_rdata = alrb;
			`RTC_A_CAL: next_rdata = {16'h0000, cal};
			`RTC_A_STAT: next_rdata = {25'h000_0000, st};
			`RTC_A_SUBSEC: next_rdata = {17'h0_0000, ss}; // RULE4
			`RTC_A_TSTIME: next_rdata = ts_time;
			`RTC_A_TSDATE: next_rdata = ts_date;
			default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// storage base is aligned to eight words, so low bits index it
	assign is_bkp = i_addr >= `RTC_A_BKP0 && i_addr < `RTC_A_BKP0 + `RTC_BKP_N;

	rtc_bkp_mem #(
		.DEPTH(BKP_N),
		.AW(3)
	) u_bkp (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_we(i_wr & is_bkp), // RULE2
		.i_waddr(i_addr[2:0]),
		.i_wdata(i_wdata),
		.i_sel_mem(i_rd & is_bkp), // RULE3
		.i_raddr(i_addr[2:0]),
		.i_bypass(next_rdata),
		.o_rdata(o_rdata)
	);
endmodule // rtc_core

/* common/rtc_defs.vh */
// constants for the bcd calendar clock with backup storage
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
// register word addresses
`define RTC_A_TIME 5'h00
`define RTC_A_DATE 5'h01
`define RTC_A_CTRL 5'h02
`define RTC_A_PRE 5'h03
`define RTC_A_WUT 5'h04
`define RTC_A_ALRA 5'h05
`define RTC_A_ALRB 5'h06
`define RTC_A_SHIFT 5'h07
`define RTC_A_CAL 5'h08
`define RTC_A_STAT 5'h09
`define RTC_A_SUBSEC 5'h0A
`define RTC_A_TSTIME 5'h0B
`define RTC_A_TSDATE 5'h0C
`define RTC_A_BKP0 5'h10
`define RTC_BKP_N 5'h05
// time and alarm word fields
`define RTC_F_SEC 6:0
`define RTC_F_SECMSK 7
`define RTC_F_MIN 14:8
`define RTC_F_MINMSK 15
`define RTC_F_HR 21:16
`define RTC_F_PM 22
`define RTC_F_HRMSK 23
`define RTC_F_ADT 29:24
`define RTC_F_DTMSK 31
// date word fields
`define RTC_F_DT 5:0
`define RTC_F_MO 12:8
`define RTC_F_WD 15:13
`define RTC_F_YR 23:16
// control word fields
`define RTC_C_FMT12 0
`define RTC_C_REFEN 1
`define RTC_C_REF60 2
`define RTC_C_ALAEN 3
`define RTC_C_ALBEN 4
`define RTC_C_WUTEN 5
`define RTC_C_WUT1HZ 6
`define RTC_C_CKSEL 8:7
`define RTC_C_TAMPEN 10:9
`define RTC_C_TSEN 11
`define RTC_C_TAMPTS 12
`define RTC_C_FILT 14:13
`define RTC_C_WAKE 22:16
`define RTC_C_W 23
// prescaler, shift and calibration fields
`define RTC_F_PREA 22:16
`define RTC_F_PRES 14:0
`define RTC_F_ADD1S 31
`define RTC_F_SUBFS 14:0
`define RTC_F_CALP 15
`define RTC_F_CALM 8:0
// status flags, write zero to clear
`define RTC_S_ALA 0
`define RTC_S_ALB 1
`define RTC_S_WUT 2
`define RTC_S_TS 3
`define RTC_S_TSOV 4
`define RTC_S_TAMP 6:5
`define RTC_S_W 7
// reset values
`define RTC_TIME_RST 32'h0000_0000
`define RTC_DATE_RST 32'h0000_2101
`define RTC_PREA_RST 7'h7F
`define RTC_PRES_RST 15'h00FF
`define RTC_WUT_RST 16'hFFFF
// calendar limits in bcd
`define RTC_MAX_SEC 8'h59
`define RTC_MAX_HR24 8'h23
`define RTC_HR11 8'h11
`define RTC_HR12 8'h12
`define RTC_ONE 8'h01
`define RTC_MAX_WD 8'h07
`define RTC_MAX_MO 8'h12
`define RTC_MAX_YR 8'h99
// reference clock periods per second, less one
`define RTC_REF50 6'h31
`define RTC_REF60 6'h3B
// calibration: one slot every 2^11 pulses, 2^20-pulse window
`define RTC_CAL_SLOT 10:0
`define RTC_CAL_IDX 19:11
`endif

/* rtl/rtc_bkp_mem.v */
// backup storage words with registered read port
`timescale 1ns/10ps
module rtc_bkp_mem #(
	parameter DEPTH = 5,
	parameter AW = 3
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_nrst,
	// write port
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [31:0] i_wdata,
	// read port and register readback bypass
	input wire i_sel_mem,
	input wire [AW-1:0] i_raddr,
	input wire [31:0] i_bypass,
	output reg [31:0] o_rdata
);
	reg [31:0] mem [0:DEPTH-1];

	// storage has no reset so its contents survive any reset
	always @(posedge i_clk_sys) begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
	end

	// one read register serves storage and all other registers
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			o_rdata <= 32'h0000_0000;
		else if (i_sel_mem)
			o_rdata <= mem[i_raddr];
		else
			o_rdata <= i_bypass;
	end
endmodule // rtc_bkp_mem

/* test/rtc_core_sva.sv */
// assertion checker bound to the bcd calendar core ports
`timescale 1ns/10ps
`include "rtc_defs.vh"
module rtc_core_sva (
	// clock, reset and register port
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [4:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	// wakeup request
	input wire o_wakeup
);
	reg [31:0] ctrl_sh;
	reg [31:0] bk_sh [0:7];
	reg [7:0] bk_v = 8'h00;
	reg [31:0] bk_exp;
	wire bk_hit = i_addr[4] && (i_addr[3:0] < 4'h5);
	wire bad_adr = i_addr[4] ? !bk_hit : (i_addr > 5'h0C);
	wire [7:0] hr = {2'b00, o_rdata[21:16]};
	wire [6:0] wk_en = ctrl_sh[`RTC_C_WAKE];

	// storage shadow is never reset, just like the words it mirrors
	always @(posedge i_clk_sys) begin
		if (i_nrst && i_wr && bk_hit) begin
			bk_sh[i_addr[2:0]] <= i_wdata;
			bk_v[i_addr[2:0]] <= 1'b1;
		end
		bk_exp <= bk_sh[i_addr[2:0]];
	end

	// control shadow follows the core reset
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_sh <= 32'h0000_0000;
		end else if (i_wr && i_addr == `RTC_A_CTRL) begin
			ctrl_sh <= i_wdata;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	AST_BKP_KEEP: assert property (i_rd && bk_hit && bk_v[i_addr[2:0]]
		|=> o_rdata == bk_exp) else $error("storage word lost");
	AST_UNMAPPED: assert property (i_rd && bad_adr |=> o_rdata == 0)
		else $error("unmapped read not zero");
	AST_SHIFT_RD: assert property (i_rd && i_addr == `RTC_A_SHIFT
		|=> o_rdata == 0) else $error("shift word reads back");
	AST_TIME_BCD: assert property (i_rd && i_addr == `RTC_A_TIME
		|=> o_rdata[3:0] < 4'hA && o_rdata[6:4] < 3'h6
		&& o_rdata[11:8] < 4'hA && o_rdata[14:12] < 3'h6)
		else $error("time digits out of bcd range");
	AST_HOUR_FMT: assert property (i_rd && i_addr == `RTC_A_TIME
		|=> o_rdata[19:16] < 4'hA && (ctrl_sh[`RTC_C_FMT12] ?
		(hr != 8'h00 && hr <= 8'h12) : hr <= 8'h23))
		else $error("hour outside selected format");
	AST_DATE_RANGE: assert property (i_rd && i_addr == `RTC_A_DATE
		|=> o_rdata[5:0] != 0 && o_rdata[5:0] <= 6'h31
		&& o_rdata[12:8] != 0 && o_rdata[12:8] <= 5'h12
		&& o_rdata[15:13] != 0) else $error("date field out of range");
	AST_WAKE_CAUSE: assert property ($rose(o_wakeup)
		|-> $past(wk_en) != 7'h00) else $error("wakeup without enable");
	AST_WAKE_OFF: assert property (wk_en == 0 && $past(wk_en) == 0
		|-> !o_wakeup) else $error("wakeup with all enables off");
endmodule // rtc_core_sva

bind rtc_core rtc_core_sva u_sva (
	.i_clk_sys(i_clk_sys),
	.i_nrst(i_nrst),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_wakeup(o_wakeup)
);

/* test/rtc_pin_model.sv */
// model of the tamper and timestamp pins outside the calendar core
`timescale 1ns/10ps
module rtc_pin_model (
	// clock and event requests from the bench
	input wire i_clk_sys,
	input wire [2:0] i_fire,
	// pins seen by the core
	output reg [1:0] o_tamper = 2'b00,
	output reg o_tstamp = 1'b0
);
	reg [3:0] hold = 4'h0;

	// a request holds its pin high nine cycles, long enough for the
	// input synchroniser; released pins fall to their pull-down level
	always @(posedge i_clk_sys) begin
		if (i_fire != 3'b000) begin
			hold <= 4'h8;
			o_tamper <= i_fire[1:0];
			o_tstamp <= i_fire[2];
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end else begin
			o_tamper <= 2'b00;
			o_tstamp <= 1'b0;
		end
	end
endmodule // rtc_pin_model

/* test/rtc_core_test.sv */
// self-checking bench for the bcd calendar core
`timescale 1ns/10ps
`include "rtc_defs.vh"
module rtc_core_test;
	typedef struct {
		logic [31:0] e;
		logic [31:0] m;
		logic [4:0] a;
	} rtc_note_t;
	reg clk_sys;
	reg nrst = 1'b0;
	reg [4:0] addr = 5'h00;
	reg [31:0] wdata = 32'h0000_0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg rd_d = 1'b0;
	reg [2:0] hc = 3'h0;
	reg [2:0] fire = 3'h0;
	wire [31:0] rdata;
	wire wakeup;
	wire [1:0] tamper;
	wire tstamp;
	rtc_note_t notes[$];
	rtc_note_t nt;
	logic [31:0] rd_val;
	logic [31:0] seed = 32'h1345_92ce;
	logic [31:0] bk [0:4];
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	// rollover cases: control, date, time, next time, next date
	logic [31:0] ro [0:5][0:4] = '{
		'{32'h0000_0180, 32'h0001_6228, 32'h0023_5959, 32'h0, 32'h0001_8301},
		'{32'h0000_0180, 32'h0004_E228, 32'h0023_5959, 32'h0, 32'h0004_2229},
		'{32'h0000_0180, 32'h0004_2430, 32'h0023_5959, 32'h0, 32'h0004_4501},
		'{32'h0000_0180, 32'h0099_5231, 32'h0023_5959, 32'h0, 32'h0000_6101},
		'{32'h0000_0181, 32'h0005_A131, 32'h0051_5959, 32'h0012_0000,
			32'h0005_C201},
		'{32'h0000_0181, 32'h0005_A331, 32'h0011_5959, 32'h0052_0000,
			32'h0005_A331}};

	rtc_core #(.HSE_DIV(2), .BKP_N(5)) i_dut (
		.i_clk_sys(clk_sys),
		.i_nrst(nrst),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr),
		.i_rd(rd),
		.o_rdata(rdata),
		.i_low_speed_external_crystal(1'b0),
		.i_ext_resonator(1'b0),
		.i_low_speed_internal_rc(1'b0),
		.i_high_speed_external_clock(hc[2]),
		.i_tamper(tamper),
		.i_tstamp(tstamp),
		.i_refclk(hc[2]),
		.o_wakeup(wakeup)
	);

	rtc_pin_model i_pins (
		.i_clk_sys(clk_sys),
		.i_fire(fire),
		.o_tamper(tamper),
		.o_tstamp(tstamp)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask

	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// a zero mask notes a read whose value is only wanted in rd_val
	task rd_reg(input logic [4:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		notes.push_back('{e & m, m, a});
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task wait_wake(input logic lvl, input int lim);
		int n;
		n = 0;
		while (wakeup !== lvl && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		chk("wakeup", {31'h0, lvl}, {31'h0, wakeup});
	endtask

	// poll until the time word moves off its written value; the first
	// second after reset runs the reset prescaler values, ~6200 cycles
	task roll_wait(input logic [31:0] t0);
		int n;
		n = 0;
		do begin
			rd_reg(`RTC_A_TIME, 32'h0000_0000, 32'h0000_0000);
			n++;
		end while ((rd_val & 32'h007F_7F7F) === t0 && n < 2400);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// high-speed source at an eighth of the system rate, under 5 MHz
	always @(posedge clk_sys) begin
		hc <= hc + 3'h1;
	end

	// read data stand the cycle after the strobe; oldest note first
	always @(posedge clk_sys) begin
		rd_d <= rd;
		if (rd_d) begin
			nt = notes.pop_front();
			rd_val = rdata;
			if (nt.m != 0) begin
				chk($sformatf("reg %h", nt.a), nt.e, rdata & nt.m);
			end
		end
	end

	// cycle ceiling cuts a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			close_out;
		end
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		// storage words must ride through a reset in mid-run
		for (i = 0; i < 5; i++) begin
			seed = xs(seed);
			bk[i] = seed;
			wr_reg(`RTC_A_BKP0 + i[4:0], seed);
		end
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd_reg(`RTC_A_BKP0 + i[4:0], bk[i], 32'hFFFF_FFFF);
		end
		rd_reg(`RTC_A_TIME, `RTC_TIME_RST, 32'hFFFF_FFFF);
		rd_reg(`RTC_A_DATE, `RTC_DATE_RST, 32'hFFFF_FFFF);
		rd_reg(`RTC_A_PRE, 32'h007F_00FF, 32'hFFFF_FFFF);
		rd_reg(5'h15, 32'h0000_0000, 32'hFFFF_FFFF);
		rd_reg(`RTC_A_SHIFT, 32'h0000_0000, 32'hFFFF_FFFF);
		// four calendar pulses a second keeps rollovers short
		wr_reg(`RTC_A_PRE, 32'h0000_0003);
		for (i = 0; i < 6; i++) begin
			wr_reg(`RTC_A_CTRL, ro[i][0]);
			wr_reg(`RTC_A_DATE, ro[i][1]);
			wr_reg(`RTC_A_TIME, ro[i][2]);
			roll_wait(ro[i][2]);
			rd_reg(`RTC_A_TIME, ro[i][3], 32'h007F_7F7F);
			rd_reg(`RTC_A_DATE, ro[i][4], 32'h00FF_FF3F);
		end
		// each alarm on seconds alone, then cleared by writing zero
		for (i = 0; i < 2; i++) begin
			wr_reg(`RTC_A_ALRA + i[4:0], 32'h8080_8005);
			wr_reg(`RTC_A_CTRL, 32'h0000_0180 | (32'h0001_0008 << i));
			wr_reg(`RTC_A_TIME, 32'h0000_0003);
			wait_wake(1'b1, 400);
			rd_reg(`RTC_A_STAT, 32'h1 << i, 32'h0000_0003);
			wr_reg(`RTC_A_STAT, 32'h0000_0000);
			wait_wake(1'b0, 4);
		end
		wr_reg(`RTC_A_WUT, 32'h0000_0002);
		wr_reg(`RTC_A_CTRL, 32'h0004_01E0);
		wait_wake(1'b1, 600);
		rd_reg(`RTC_A_STAT, 32'h0000_0004, 32'h0000_0004);
		wr_reg(`RTC_A_STAT, 32'h0000_0000);
		// reference pacing: 50 Hz ticks within 440 cycles, 60 Hz not yet
		for (i = 0; i < 2; i++) begin
			wr_reg(`RTC_A_CTRL, 32'h0000_0000);
			wr_reg(`RTC_A_CTRL, 32'h0000_0002 | (i << 2));
			wr_reg(`RTC_A_TIME, 32'h0000_0010);
			repeat (440) @(posedge clk_sys);
			rd_reg(`RTC_A_TIME, 32'h0000_0011 - i, 32'h007F_7F7F);
		end
		// a shift write adds one second to a stopped calendar
		wr_reg(`RTC_A_CTRL, 32'h0000_0000);
		wr_reg(`RTC_A_TIME, 32'h0000_0010);
		wr_reg(`RTC_A_SHIFT, 32'h8000_0001);
		rd_reg(`RTC_A_TIME, 32'h0000_0011, 32'h007F_7F7F);
		// calendar frozen on the idle crystal so captures are exact
		for (i = 0; i < 3; i++) begin
			wr_reg(`RTC_A_CTRL, i == 0 ? 32'h0008_0800 :
				32'h0000_1000 | (32'h0010_0100 << i));
			wr_reg(`RTC_A_DATE, 32'h0007_4615);
			wr_reg(`RTC_A_TIME, 32'h0012_3456 + i);
			@(posedge clk_sys);
			fire <= (i == 0) ? 3'b100 : i[2:0];
			@(posedge clk_sys);
			fire <= 3'b000;
			wait_wake(1'b1, 40);
			rd_reg(`RTC_A_STAT, i == 0 ? 32'h8 : 32'h8 | (32'h10 << i),
				32'h0000_0068);
			rd_reg(`RTC_A_TSTIME, 32'h0012_3456 + i, 32'h007F_7F7F);
			rd_reg(`RTC_A_TSDATE, 32'h0007_4615, 32'h00FF_FF3F);
			rd_reg(`RTC_A_TIME, 32'h0012_3456 + i, 32'h007F_7F7F);
			wr_reg(`RTC_A_STAT, 32'h0000_0000);
			wait_wake(1'b0, 4);
		end
		close_out;
	end
endmodule // rtc_core_test
